// file: design/slcd_regs.svh
// register indices, field positions, reset values and timing counts of the segment lcd driver
`ifndef SLCD_REGS_SVH
`define SLCD_REGS_SVH

// =====================================================================
// register indices (byte address = 4 * index)
`define SLCD_IDX_DRIVE_VOLTAGE_MODE 16'hFFB0
`define SLCD_IDX_DISPLAY_MODE 16'hFFB1
`define SLCD_IDX_CLOCK_CONTROL 16'hFFB2
`define SLCD_IDX_SELECT_LOW 16'hFFB5
`define SLCD_IDX_SELECT_HIGH 16'hFFB6
`define SLCD_IDX_MEM_FIRST 16'hFA40
`define SLCD_IDX_MEM_LAST 16'hFA55
`define SLCD_MEM_BYTES 22
`define SLCD_MEM_NARROW 4

// =====================================================================
// field positions
`define SLCD_SRC_LSB 4
`define SLCD_SCAN_LSB 0
`define SLCD_MODE_DISPLAY_ON 7
`define SLCD_MODE_PIN_OUT 6
`define SLCD_MODE_BOOST 4
`define SLCD_MODE_SLICE_LSB 0

// =====================================================================
// writable masks and reset values
`define SLCD_CLOCK_CONTROL_MASK 8'h77
`define SLCD_DISPLAY_MODE_MASK 8'hD7
`define SLCD_DRIVE_VOLTAGE_MASK 8'h30
`define SLCD_SELECT_LOW_MASK 8'h3F
`define SLCD_SELECT_HIGH_MASK 8'h6C
`define SLCD_RESET_VALUE 8'h00

// =====================================================================
// divider spans
`define SLCD_LOW_SPEED_DIV 3'h7
`define SLCD_SCAN_MIN_SHIFT 4

`endif

// file: design/slcd_pkg.sv
// types shared by the segment lcd driver
package slcd_pkg;

    // =====================================================================
    // source clock choices
    typedef enum logic [2:0] {
        SLCD_SRC_CRYSTAL = 3'h0,
        SLCD_SRC_PRS_64 = 3'h1,
        SLCD_SRC_PRS_128 = 3'h2,
        SLCD_SRC_PRS_256 = 3'h3,
        SLCD_SRC_LOW_SPEED = 3'h4
    } slcd_src_t;

    // =====================================================================
    // slice count codes
    typedef enum logic [2:0] {
        SLCD_SLICE_FOUR = 3'h0,
        SLCD_SLICE_THREE_B3 = 3'h1,
        SLCD_SLICE_TWO = 3'h2,
        SLCD_SLICE_THREE_B2 = 3'h3,
        SLCD_SLICE_STATIC = 3'h4,
        SLCD_SLICE_EIGHT = 3'h7
    } slcd_slice_t;

endpackage : slcd_pkg

// file: design/slcd_scan_driver.sv
// segment lcd scan driver: wishbone registers, display memory, clock dividers and common/segment scan
//
// How it works
// - source clock field picks crystal, peripheral /64 /128 /256 or low-speed /8
// - scan field divides source clock by 16 up to 512; other codes stop scan
// - frame length is scan clock period times configured slice count
// - reset clears clock control; byte writes set whole register
// - low select bits 5..0 switch each shared pin between port and segment
// - high select bits 2,3,5,6 switch pins; other bits read zero
// - pin output on, display off gives non-selected waveforms on every segment; commons still scan
// - display on drives segments from display memory contents
// - 22 byte display memory, unused locations act as plain ram
// - upper nibble of first four memory bytes absent, reads zero
// - commons selected in turn by slice count; static drives commons 0-3 alike
// - memory bits 0..3 serve common slices 0..3 on matching segment
// - bit one gives select level, bit zero gives deselect level
// - unused high bits per mode are ignored and stay free storage
// - panel driven with alternating polarity, no net dc on pixels
// - pixel on only when both common and segment are at select
// - commons 4 to 7 driven only in eight-slice mode
// - slice code: 7 eight, 0 four, 1/3 three, 2 two, 4 static
// - display off holds every segment at deselect
// - pin output off drives ground on all segment and common pins
// - each time slice lasts one scan clock period
`timescale 1ns/10ps
`include "slcd_regs.svh"

module slcd_scan_driver (
    input wire logic clk, // 100 MHz system clock, also peripheral clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [17:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic crystal_tick, // one-cycle pulse per subsystem crystal period
    input wire logic low_speed_tick, // one-cycle pulse per low-speed oscillator period
    output logic [7:0] common_select, // common at select level in this slice
    output logic [7:0] common_active, // pin is driven as a common
    output logic [21:0] segment_select, // segment at select level in this slice
    output logic drive_polarity, // current frame polarity
    output logic pin_drive_enable, // low: all panel pins at ground
    output logic scan_tick, // one-cycle pulse at each slice start
    output logic [5:0] low_pin_segment_enable, // shared low pins used as segments
    output logic [3:0] high_pin_segment_enable, // shared high pins used as segments
    output logic gate_boost_enable, // gate voltage boost request
    output logic [1:0] voltage_method_select // drive voltage generator method
);

    // =====================================================================
    // helpers
    function automatic logic [2:0] slice_last(input logic [2:0] code);
        unique case (code)
            3'h7: slice_last = 3'h7;
            3'h0: slice_last = 3'h3;
            3'h1, 3'h3: slice_last = 3'h2;
            3'h2: slice_last = 3'h1;
            default: slice_last = 3'h0;
        endcase
    endfunction : slice_last

    function automatic logic slice_legal(input logic [2:0] code);
        slice_legal = (code <= 3'h4) || (code == 3'h7);
    endfunction : slice_legal

    // =====================================================================
    // registers
    logic [7:0] clock_control_q;
    logic [7:0] display_mode_q;
    logic [7:0] drive_voltage_mode_q;
    logic [7:0] select_low_q;
    logic [7:0] select_high_q;
    logic [7:0] mem_q [0:`SLCD_MEM_BYTES-1];

    logic [15:0] index;
    logic bus_req;
    logic wr_en;
    logic mem_hit;
    logic [4:0] mem_slot;
    logic [15:0] mem_offset;

    assign index = wb_adr_i[17:2];
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
    assign mem_hit = (index >= `SLCD_IDX_MEM_FIRST) && (index <= `SLCD_IDX_MEM_LAST);
    assign mem_offset = index - `SLCD_IDX_MEM_FIRST;
    assign mem_slot = mem_offset[4:0];

    // bits 3 and 7 never store, so a careless write cannot reach a prohibited code there
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clock_control_q <= `SLCD_RESET_VALUE;
        end else if (wr_en && index == `SLCD_IDX_CLOCK_CONTROL) begin
            clock_control_q <= wb_dat_i[7:0] & `SLCD_CLOCK_CONTROL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            display_mode_q <= `SLCD_RESET_VALUE;
            drive_voltage_mode_q <= `SLCD_RESET_VALUE;
        end else if (wr_en && index == `SLCD_IDX_DISPLAY_MODE) begin
            display_mode_q <= wb_dat_i[7:0] & `SLCD_DISPLAY_MODE_MASK;
        end else if (wr_en && index == `SLCD_IDX_DRIVE_VOLTAGE_MODE) begin
            drive_voltage_mode_q <= wb_dat_i[7:0] & `SLCD_DRIVE_VOLTAGE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            select_low_q <= `SLCD_RESET_VALUE;
            select_high_q <= `SLCD_RESET_VALUE;
        end else if (wr_en && index == `SLCD_IDX_SELECT_LOW) begin
            select_low_q <= wb_dat_i[7:0] & `SLCD_SELECT_LOW_MASK;
        end else if (wr_en && index == `SLCD_IDX_SELECT_HIGH) begin
            select_high_q <= wb_dat_i[7:0] & `SLCD_SELECT_HIGH_MASK;
        end
    end

    // display memory keeps every bit except the upper nibble of bytes 0..3, so unused slice bits work as plain storage
    genvar g;
    generate
        for (g = 0; g < `SLCD_MEM_BYTES; g++) begin : g_mem
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    mem_q[g] <= `SLCD_RESET_VALUE;
                end else if (wr_en && mem_hit && mem_slot == 5'(g)) begin
                    if (g < `SLCD_MEM_NARROW) begin
                        mem_q[g] <= {4'h0, wb_dat_i[3:0]};
                    end else begin
                        mem_q[g] <= wb_dat_i[7:0];
                    end
                end
            end
        end
    endgenerate

    // =====================================================================
    // wishbone answer: ack one cycle after the request, unmapped reads zero
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (mem_hit) begin
            rd_byte = mem_q[mem_slot];
        end else begin
            unique case (index)
                `SLCD_IDX_CLOCK_CONTROL: rd_byte = clock_control_q;
                `SLCD_IDX_DISPLAY_MODE: rd_byte = display_mode_q;
                `SLCD_IDX_DRIVE_VOLTAGE_MODE: rd_byte = drive_voltage_mode_q;
                `SLCD_IDX_SELECT_LOW: rd_byte = select_low_q;
                `SLCD_IDX_SELECT_HIGH: rd_byte = select_high_q;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // =====================================================================
    // source clock selection
    logic [7:0] prs_cnt_q;
    logic [2:0] rl_cnt_q;
    logic src_tick;
    logic [2:0] src_code;

    assign src_code = clock_control_q[`SLCD_SRC_LSB +: 3];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prs_cnt_q <= 8'h00;
        end else begin
            prs_cnt_q <= prs_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rl_cnt_q <= 3'h0;
        end else if (low_speed_tick) begin
            rl_cnt_q <= rl_cnt_q + 3'h1;
        end
    end

    // prohibited source codes give no ticks, so the scan simply freezes
    always_comb begin
        src_tick = 1'b0;
        unique case (src_code)
            slcd_pkg::SLCD_SRC_CRYSTAL: src_tick = crystal_tick;
            slcd_pkg::SLCD_SRC_PRS_64: src_tick = (prs_cnt_q[5:0] == 6'h3F);
            slcd_pkg::SLCD_SRC_PRS_128: src_tick = (prs_cnt_q[6:0] == 7'h7F);
            slcd_pkg::SLCD_SRC_PRS_256: src_tick = (prs_cnt_q == 8'hFF);
            slcd_pkg::SLCD_SRC_LOW_SPEED: src_tick = low_speed_tick && (rl_cnt_q == `SLCD_LOW_SPEED_DIV);
            default: src_tick = 1'b0;
        endcase
    end

    // =====================================================================
    // scan clock divider, one tick per slice
    logic [8:0] scan_cnt_q;
    logic [2:0] scan_code;
    logic [8:0] scan_mask;
    logic scan_legal;
    logic slice_end;

    assign scan_code = clock_control_q[`SLCD_SCAN_LSB +: 3];
    assign scan_legal = (scan_code <= 3'h5);
    assign scan_mask = 9'((10'h001 << (`SLCD_SCAN_MIN_SHIFT + scan_code)) - 10'h001);
    assign slice_end = scan_legal && src_tick && ((scan_cnt_q & scan_mask) == scan_mask);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_cnt_q <= 9'h000;
        end else if (!scan_legal) begin
            scan_cnt_q <= 9'h000;
        end else if (src_tick) begin
            scan_cnt_q <= slice_end ? 9'h000 : scan_cnt_q + 9'h001;
        end
    end

    // =====================================================================
    // slice sequencer and frame polarity
    logic [2:0] slice_code;
    logic [2:0] slice_q;
    logic polarity_q;
    logic frame_end;

    assign slice_code = display_mode_q[`SLCD_MODE_SLICE_LSB +: 3];
    assign frame_end = slice_end && (slice_q >= slice_last(slice_code));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slice_q <= 3'h0;
        end else if (!slice_legal(slice_code)) begin
            slice_q <= 3'h0;
        end else if (slice_end) begin
            slice_q <= frame_end ? 3'h0 : slice_q + 3'h1;
        end
    end

    // inverting once per frame balances the drive over every pair of frames
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            polarity_q <= 1'b0;
        end else if (frame_end) begin
            polarity_q <= !polarity_q;
        end
    end

    // =====================================================================
    // common and segment levels
    logic pin_on;
    logic disp_on;
    logic [7:0] com_d;
    logic [7:0] com_act_d;
    logic [21:0] seg_d;

    assign pin_on = display_mode_q[`SLCD_MODE_PIN_OUT];
    assign disp_on = display_mode_q[`SLCD_MODE_DISPLAY_ON];

    always_comb begin
        com_d = 8'h00;
        com_act_d = 8'h00;
        unique case (slice_code)
            slcd_pkg::SLCD_SLICE_EIGHT: begin
                com_act_d = 8'hFF;
                com_d = 8'(8'h01 << slice_q);
            end
            slcd_pkg::SLCD_SLICE_FOUR: begin
                com_act_d = 8'h0F;
                com_d = 8'(8'h01 << slice_q[1:0]);
            end
            slcd_pkg::SLCD_SLICE_THREE_B3, slcd_pkg::SLCD_SLICE_THREE_B2: begin
                com_act_d = 8'h07;
                com_d = 8'(8'h01 << slice_q[1:0]);
            end
            slcd_pkg::SLCD_SLICE_TWO: begin
                com_act_d = 8'h03;
                com_d = 8'(8'h01 << slice_q[0]);
            end
            slcd_pkg::SLCD_SLICE_STATIC: begin
                com_act_d = 8'h0F;
                com_d = 8'h0F;
            end
            default: begin
                com_act_d = 8'h00;
                com_d = 8'h00;
            end
        endcase
        if (!pin_on) begin
            com_act_d = 8'h00;
            com_d = 8'h00;
        end
    end

    // only the low nibble feeds the scan; higher slices of eight-slice mode reuse bits 0..3
    generate
        for (g = 0; g < `SLCD_MEM_BYTES; g++) begin : g_seg
            always_comb begin
                seg_d[g] = mem_q[g][slice_q[1:0]];
                if (!pin_on || !disp_on) begin
                    seg_d[g] = 1'b0;
                end
            end
        end
    endgenerate

    // full on-voltage arises outside only where both common and segment are selected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            common_select <= 8'h00;
            common_active <= 8'h00;
            segment_select <= 22'h00_0000;
            drive_polarity <= 1'b0;
            pin_drive_enable <= 1'b0;
            scan_tick <= 1'b0;
        end else begin
            common_select <= com_d;
            common_active <= com_act_d;
            segment_select <= seg_d;
            drive_polarity <= polarity_q;
            pin_drive_enable <= pin_on;
            scan_tick <= slice_end;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_pin_segment_enable <= 6'h00;
            high_pin_segment_enable <= 4'h0;
            gate_boost_enable <= 1'b0;
            voltage_method_select <= 2'h0;
        end else begin
            low_pin_segment_enable <= select_low_q[5:0];
            high_pin_segment_enable <= {select_high_q[6:5], select_high_q[3:2]};
            gate_boost_enable <= display_mode_q[`SLCD_MODE_BOOST];
            voltage_method_select <= drive_voltage_mode_q[5:4];
        end
    end

endmodule : slcd_scan_driver

// file: sim/slcd_scan_driver_sva.sv
// port checker of the segment lcd scan driver
`timescale 1ns/10ps
// ==========
// checker
module slcd_scan_driver_sva (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic [7:0] common_select, // commons at select
    input wire logic [7:0] common_active, // commons driven
    input wire logic [21:0] segment_select, // segments at select
    input wire logic drive_polarity, // frame polarity
    input wire logic pin_drive_enable, // pins driven
    input wire logic scan_tick // slice pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // outputs are registered, so allow two cycles of lag behind the slice pulse
    sequence s_near_tick;
        scan_tick || $past(scan_tick) || $past(scan_tick, 2);
    endsequence
    a_req_answered: assert property (s_req |=> s_ack_pulse)
        else $error("request not answered by one ack pulse");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_data_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    a_pins_grounded: assert property (!pin_drive_enable && !$past(pin_drive_enable) |->
        common_select == 8'h0 && common_active == 8'h0 && segment_select == 22'h0)
        else $error("panel pins driven while output off");
    a_upper_commons: assert property (|common_active[7:4] |-> common_active == 8'hFF)
        else $error("upper commons driven outside eight-slice mode");
    a_common_pattern: assert property (common_select != 8'h0 |->
        $onehot(common_select) || common_select == 8'h0F)
        else $error("common select pattern not one-hot or static");
    a_slice_min_len: assert property (scan_tick |=> !scan_tick [*8])
        else $error("slice shorter than one scan clock period");
    a_polarity_at_wrap: assert property ($changed(drive_polarity) |-> s_near_tick)
        else $error("polarity changed away from a slice boundary");
    a_scan_steady: assert property ($changed(common_select) && pin_drive_enable && $past(pin_drive_enable)
        && $past(pin_drive_enable, 2) |-> s_near_tick)
        else $error("common select changed inside a slice");
endmodule : slcd_scan_driver_sva

bind slcd_scan_driver slcd_scan_driver_sva u_sva (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .common_select(common_select),
    .common_active(common_active), .segment_select(segment_select), .drive_polarity(drive_polarity),
    .pin_drive_enable(pin_drive_enable), .scan_tick(scan_tick));

// file: sim/slcd_panel_model.sv
// model of one pixel of the multiplexed glass panel
`timescale 1ns/10ps
// ==========
// panel pixel at segment 0 and common 0
module slcd_panel_model (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic [7:0] common_select, // commons at select
    input wire logic [21:0] segment_select, // segments at select
    input wire logic drive_polarity, // frame polarity
    input wire logic pin_drive_enable, // pins driven
    output int lit_cycles, // cycles with full on-voltage
    output int dc_balance // signed sum of on-time
);
    // one pixel only: enough to see on-voltage and net dc without a full panel
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lit_cycles <= 0;
            dc_balance <= 0;
        end else if (pin_drive_enable && common_select[0] && segment_select[0]) begin
            lit_cycles <= lit_cycles + 1;
            dc_balance <= dc_balance + (drive_polarity ? 1 : -1);
        end
    end
endmodule : slcd_panel_model

// file: sim/tb_slcd_scan_driver.sv
// self-checking testbench of the segment lcd scan driver
`timescale 1ns/10ps
`include "slcd_regs.svh"
// ==========
// bench
module tb_slcd_scan_driver;
    logic clk, rst_n, cyc, stb, we, crystal_tick, low_speed_tick, ack, pol, pin_en, tick, boost;
    logic [17:0] adr;
    logic [3:0] sel, hi_en;
    logic [31:0] wdat, rdat;
    logic [7:0] com_sel, com_act;
    logic [21:0] seg_sel;
    logic [5:0] lo_en;
    logic [1:0] vsel;
    logic [7:0] mem [22];
    logic [2:0] codes [6] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    logic [7:0] acts [6] = '{8'hFF, 8'h0F, 8'h07, 8'h03, 8'h07, 8'h0F};
    int nsls [6] = '{8, 4, 3, 2, 3, 1};
    int n_mismatch, n_compared, cycles, div_cnt, lit_cycles, dc_balance;
    slcd_scan_driver u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .crystal_tick(crystal_tick), .low_speed_tick(low_speed_tick), .common_select(com_sel),
        .common_active(com_act), .segment_select(seg_sel), .drive_polarity(pol), .pin_drive_enable(pin_en),
        .scan_tick(tick), .low_pin_segment_enable(lo_en), .high_pin_segment_enable(hi_en),
        .gate_boost_enable(boost), .voltage_method_select(vsel));
    slcd_panel_model u_panel (.clk(clk), .rst_n(rst_n), .common_select(com_sel), .segment_select(seg_sel),
        .drive_polarity(pol), .pin_drive_enable(pin_en), .lit_cycles(lit_cycles), .dc_balance(dc_balance));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // crystal pulse every 20 clocks, low-speed pulse every 5
    always @(posedge clk) begin
        div_cnt <= (div_cnt == 19) ? 0 : div_cnt + 1;
        crystal_tick <= (div_cnt == 19);
        low_speed_tick <= (div_cnt % 5 == 4);
        cycles++;
        if (cycles == 100000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic [15:0] idx, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        check(n, 2, "ack latency");
    endtask : xfer
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        xfer(idx, 1'b1, d, q);
    endtask : wr
    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] q;
        xfer(idx, 1'b0, 8'h00, q);
        check(q, exp, what);
    endtask : rdchk
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 30000);
    endtask : tick_gap
    task automatic slice_len(input logic [7:0] cc, input int exp);
        int n;
        wr(`SLCD_IDX_CLOCK_CONTROL, cc);
        tick_gap(n);
        tick_gap(n);
        check(n, exp, "slice length");
    endtask : slice_len
    task automatic mode_run(input logic [2:0] code, input int nsl, input logic [7:0] act);
        int n, k, idx, prev;
        logic p;
        logic [21:0] exp;
        wr(`SLCD_IDX_DISPLAY_MODE, {5'h00, code});
        wr(`SLCD_IDX_DISPLAY_MODE, {5'h1A, code});
        tick_gap(n);
        for (k = 0; k < 2; k++) begin
            p = pol;
            n = 0;
            while (pol === p && n < 9000) begin
                @(posedge clk);
                n++;
            end
        end
        check(n, nsl * 320, "frame length");
        prev = -1;
        for (k = 0; k < nsl; k++) begin
            tick_gap(n);
            repeat (3) @(posedge clk);
            idx = 0;
            while (idx < 7 && com_sel[idx] !== 1'b1) idx++;
            for (int g = 0; g < 22; g++) exp[g] = mem[g][(nsl == 1) ? 0 : idx % 4];
            check(com_sel, (nsl == 1) ? 8'h0F : 8'h01 << idx, "commons");
            check(seg_sel, exp, "segments");
            if (prev >= 0) check(idx, (prev + 1) % nsl, "slice order");
            prev = idx;
            check(com_act, act, "common pins");
        end
    endtask : mode_run
    initial begin
        int n;
        rst_n = 1'b0;
        {cyc, stb, we, crystal_tick, low_speed_tick} = 5'h00;
        adr = 18'h0;
        sel = 4'h0;
        wdat = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`SLCD_IDX_CLOCK_CONTROL, 8'h00, "clock reset");
        rdchk(`SLCD_IDX_SELECT_LOW, 8'h00, "low select reset");
        rdchk(`SLCD_IDX_SELECT_HIGH, 8'h00, "high select reset");
        wr(`SLCD_IDX_CLOCK_CONTROL, 8'h45); // bits 3 and 7 kept zero
        rdchk(`SLCD_IDX_CLOCK_CONTROL, 8'h45, "clock byte write");
        wr(16'h0000, 8'hFF);
        rdchk(16'h0000, 8'h00, "unmapped read");
        wr(`SLCD_IDX_DISPLAY_MODE, 8'h10); // setup order: boost first
        wr(`SLCD_IDX_DRIVE_VOLTAGE_MODE, 8'h10);
        // pin outputs copy their registers one clock after the write
        @(posedge clk);
        check({boost, vsel}, 3'h5, "boost and voltage method");
        wr(`SLCD_IDX_SELECT_LOW, 8'hFF);
        rdchk(`SLCD_IDX_SELECT_LOW, 8'h3F, "low select mask");
        check(lo_en, 6'h3F, "low pin enables");
        wr(`SLCD_IDX_SELECT_HIGH, 8'hFF);
        rdchk(`SLCD_IDX_SELECT_HIGH, 8'h6C, "high select mask");
        wr(`SLCD_IDX_SELECT_HIGH, 8'h44);
        @(posedge clk);
        check(hi_en, 4'h9, "high pin enables");
        for (int g = 0; g < 22; g++) begin
            mem[g] = 8'hA5 ^ 8'(g * 17);
            wr(16'(`SLCD_IDX_MEM_FIRST + g), mem[g]);
            if (g < 4) mem[g] = mem[g] & 8'h0F;
            rdchk(16'(`SLCD_IDX_MEM_FIRST + g), mem[g], "display memory");
        end
        wr(`SLCD_IDX_DISPLAY_MODE, 8'h10);
        wr(`SLCD_IDX_CLOCK_CONTROL, 8'h00);
        wr(`SLCD_IDX_DISPLAY_MODE, 8'h50);
        tick_gap(n);
        tick_gap(n);
        repeat (3) @(posedge clk);
        check(seg_sel, 22'h0, "blank segments");
        check(com_sel != 8'h0, 1'b1, "blank commons scan");
        for (int m = 0; m < 6; m++) mode_run(codes[m], nsls[m], acts[m]);
        // slice count only changes with pin output off, as the setup order asks
        wr(`SLCD_IDX_DISPLAY_MODE, 8'h00);
        wr(`SLCD_IDX_DISPLAY_MODE, 8'hD0);
        slice_len(8'h10, 1024);
        slice_len(8'h20, 2048);
        slice_len(8'h30, 4096);
        slice_len(8'h40, 640);
        for (int k = 0; k < 6; k++) slice_len(8'(k), 320 << k);
        check(lit_cycles > 0, 1'b1, "pixel lit");
        check(dc_balance <= 10240 && dc_balance >= -10240, 1'b1, "pixel dc");
        wr(`SLCD_IDX_CLOCK_CONTROL, 8'h06);
        n = 0;
        repeat (700) begin
            @(posedge clk);
            n += tick;
        end
        check(n, 0, "prohibited scan code");
        complete_run();
    end
endmodule : tb_slcd_scan_driver
